// file: rtl/sdac_fifo.v
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: Single clock; depth is a power of two
// Notes:   One cycle from memory fetch to out_valid
`timescale 1ns/1ps
module sdac_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level, output stage included
  output wire [AW+1:0] level
);

  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] mem_cnt;
  wire push;
  wire fetch;

  // Full counts only the memory, so the output stage adds one slot
  assign in_ready = (mem_cnt != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  // Fetch never hits the slot being written: memory must be nonempty
  assign fetch = (mem_cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  assign level = {1'b0, mem_cnt} + {{(AW+1){1'b0}}, out_valid};

  // ========================================================
  // Pointers, count and output valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      mem_cnt <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fetch) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      mem_cnt <= mem_cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, fetch};
      if (fetch) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  sdac_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .pclk(pclk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data(in_data),
    .rd_en(fetch),
    .rd_addr(rd_ptr),
    .rd_data(out_data)
  );

endmodule // sdac_fifo

// file: rtl/sdac_mem.v
// Purpose: Small word memory with registered read data
// Assumes: One write and one read port on pclk
// Notes:   Read data change only when rd_en is high
`timescale 1ns/1ps
module sdac_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock
  input wire pclk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];

  // ========================================================
  // Storage; no reset so it maps onto plain RAM
  always @(posedge pclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule // sdac_mem

// file: rtl/sdac_regs.vh
// Purpose: Shared constants of the serial converter front end
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses on the register bus
`ifndef SDAC_REGS_VH
`define SDAC_REGS_VH

// ==========================================================
// Register offsets
`define SDAC_OFS_CTRL 8'h00
`define SDAC_OFS_STATUS 8'h04
`define SDAC_OFS_VALUE 8'h08
`define SDAC_OFS_LEVEL 8'h0C

// ==========================================================
// Control and status field positions
`define SDAC_CTRL_HOLD 0
`define SDAC_ST_EMPTY 0
`define SDAC_ST_FULL 1
`define SDAC_ST_OVERFLOW 2
`define SDAC_ST_ABORT 3
`define SDAC_ST_VALID 4
`define SDAC_ST_ACTIVE 5

// ==========================================================
// Serial word layout
`define SDAC_WORD_BITS 16
`define SDAC_MODE_HI 15
`define SDAC_MODE_LO 14
`define SDAC_VAL_HI 13
`define SDAC_VAL_LO 6

// ==========================================================
// Mode codes and reset values
`define SDAC_MODE_NORMAL 2'h0
`define SDAC_MODE_1K 2'h1
`define SDAC_MODE_100K 2'h2
`define SDAC_MODE_HIZ 2'h3
`define SDAC_RST_VALUE 8'h00
`define SDAC_RST_MODE 2'h0
`define SDAC_RST_CTRL 1'b0

// ==========================================================
// Timing
`define SDAC_CLK_MHZ 10
`define SDAC_WAKE_US 50
`define SDAC_WAKE_CYC (`SDAC_WAKE_US * `SDAC_CLK_MHZ)

`endif

// file: rtl/sdac_top.v
// Purpose: Serial input and mode control of an 8-bit converter
// Assumes: Link pins are asynchronous to pclk and far slower
// Notes:   Link edges are found by oversampling on pclk
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sdac_regs.vh"

module sdac_top #(
  parameter WAKE_CYC = `SDAC_WAKE_CYC,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Serial link pins
  input wire sync_n,
  input wire sclk,
  input wire din,
  // Converter core controls
  output reg [7:0] conv_value,
  output wire pwrdn_sel_hi,
  output wire pwrdn_sel_lo,
  output wire amp_enable,
  output wire load_1k,
  output wire load_100k,
  output wire load_hiz,
  output reg output_valid
);

  localparam WB = `SDAC_WORD_BITS;

  // Synchroniser and edge history
  reg [1:0] sync_sy;
  reg [1:0] sclk_sy;
  reg [1:0] din_sy;
  reg sync_d;
  reg sclk_d;
  // Frame state
  reg active;
  reg [4:0] bit_cnt;
  reg [WB-1:0] shreg;
  reg word_stb;
  reg [WB-1:0] word;
  // Held mode and control
  reg [1:0] mode;
  reg hold;
  reg overflow;
  reg abort_seen;
  reg [15:0] wake_cnt;
  // FIFO side
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WB-1:0] fifo_out_data;
  wire [AW+1:0] fifo_level;
  wire apply;
  // Link events
  wire sync_s;
  wire sclk_s;
  wire din_s;
  wire sync_fall;
  wire sync_rise;
  wire sclk_fall;
  // Bus decode
  wire wr_acc;
  wire setup;
  wire mapped;

  // ========================================================
  // Helpers
  function is_pwrdn;
    input [1:0] m;
    begin
      is_pwrdn = (m != `SDAC_MODE_NORMAL);
    end
  endfunction

  function known_addr;
    input [7:0] a;
    begin
      known_addr = (a == `SDAC_OFS_CTRL) || (a == `SDAC_OFS_STATUS) ||
        (a == `SDAC_OFS_VALUE) || (a == `SDAC_OFS_LEVEL);
    end
  endfunction

  // ========================================================
  // Pin synchronisers; only the second stage feeds logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sy <= 2'b11;
      sclk_sy <= 2'b00;
      din_sy <= 2'b00;
      sync_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sync_sy <= {sync_sy[0], sync_n};
      sclk_sy <= {sclk_sy[0], sclk};
      din_sy <= {din_sy[0], din};
      sync_d <= sync_sy[1];
      sclk_d <= sclk_sy[1];
    end
  end

  assign sync_s = sync_sy[1];
  assign sclk_s = sclk_sy[1];
  assign din_s = din_sy[1];
  // Edge detectors; serial clock must be well under pclk/4
  assign sync_fall = sync_d & ~sync_s;
  assign sync_rise = ~sync_d & sync_s;
  assign sclk_fall = sclk_d & ~sclk_s;

  // ========================================================
  // Frame receiver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      bit_cnt <= 5'h00;
      shreg <= {WB{1'b0}};
      word_stb <= 1'b0;
      word <= {WB{1'b0}};
      abort_seen <= 1'b0;
    end else begin
      word_stb <= 1'b0;
      if (wr_acc && paddr == `SDAC_OFS_STATUS &&
          pwdata[`SDAC_ST_ABORT]) begin
        abort_seen <= 1'b0;
      end
      if (sync_fall) begin
        // New word begins only at the sync edge
        active <= 1'b1;
        bit_cnt <= 5'h00;
        shreg <= {WB{1'b0}};
      end else if (sync_rise) begin
        // Early release: drop the partial word, keep outputs
        if (active) begin
          abort_seen <= 1'b1;
        end
        active <= 1'b0;
        bit_cnt <= 5'h00;
        shreg <= {WB{1'b0}};
      end else if (active && sclk_fall) begin
        // First bit lands on top after sixteen shifts
        shreg <= {shreg[WB-2:0], din_s};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == WB[4:0] - 5'h01) begin
          word <= {shreg[WB-2:0], din_s};
          word_stb <= 1'b1;
          active <= 1'b0;
        end
      end
    end
  end

  // ========================================================
  // Word buffer; drain stalls while software holds updates
  sdac_fifo #(.WIDTH(WB), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(word_stb),
    .in_ready(fifo_in_ready),
    .in_data(word),
    .out_valid(fifo_out_valid),
    .out_ready(~hold),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign apply = fifo_out_valid & ~hold;

  // ========================================================
  // Converter value and mode; a power-down word loads its value too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_value <= `SDAC_RST_VALUE;
      mode <= `SDAC_RST_MODE;
    end else if (apply) begin
      // Trailing six bits are never looked at
      mode <= fifo_out_data[`SDAC_MODE_HI:`SDAC_MODE_LO];
      conv_value <= fifo_out_data[`SDAC_VAL_HI:`SDAC_VAL_LO];
    end
  end

  // Output stage select from the held mode
  assign pwrdn_sel_hi = mode[1];
  assign pwrdn_sel_lo = mode[0];
  assign amp_enable = ~is_pwrdn(mode);
  assign load_1k = (mode == `SDAC_MODE_1K);
  assign load_100k = (mode == `SDAC_MODE_100K);
  assign load_hiz = (mode == `SDAC_MODE_HIZ);

  // ========================================================
  // Wake timer: output trusted only after amplifier settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt <= 16'h0000;
      output_valid <= 1'b1;
    end else if (apply &&
        is_pwrdn(fifo_out_data[`SDAC_MODE_HI:`SDAC_MODE_LO])) begin
      // Power-down drops valid at once, even in mid-wake
      wake_cnt <= 16'h0000;
      output_valid <= 1'b0;
    end else if (apply && is_pwrdn(mode)) begin
      // Leaving power-down: restart the settle count
      wake_cnt <= WAKE_CYC[15:0];
      output_valid <= 1'b0;
    end else if (is_pwrdn(mode)) begin
      wake_cnt <= 16'h0000;
      output_valid <= 1'b0;
    end else if (wake_cnt != 16'h0000) begin
      wake_cnt <= wake_cnt - 16'h0001;
      output_valid <= (wake_cnt == 16'h0001);
    end
  end

  // ========================================================
  // APB slave: zero wait, read data latched in setup phase
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign mapped = known_addr(paddr);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign pslverr = psel & penable & ~mapped;

  // Control and sticky overflow; a new overflow beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= `SDAC_RST_CTRL;
      overflow <= 1'b0;
    end else begin
      if (wr_acc && paddr == `SDAC_OFS_CTRL) begin
        hold <= pwdata[`SDAC_CTRL_HOLD];
      end
      if (word_stb && !fifo_in_ready) begin
        overflow <= 1'b1;
      end else if (wr_acc && paddr == `SDAC_OFS_STATUS &&
          pwdata[`SDAC_ST_OVERFLOW]) begin
        overflow <= 1'b0;
      end
    end
  end

  // Read mux, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `SDAC_OFS_CTRL: begin
          prdata[`SDAC_CTRL_HOLD] <= hold;
        end
        `SDAC_OFS_STATUS: begin
          prdata[`SDAC_ST_EMPTY] <= (fifo_level == {(AW+2){1'b0}});
          prdata[`SDAC_ST_FULL] <= ~fifo_in_ready;
          prdata[`SDAC_ST_OVERFLOW] <= overflow;
          prdata[`SDAC_ST_ABORT] <= abort_seen;
          prdata[`SDAC_ST_VALID] <= output_valid;
          prdata[`SDAC_ST_ACTIVE] <= active;
        end
        `SDAC_OFS_VALUE: begin
          prdata[7:0] <= conv_value;
          prdata[9:8] <= mode;
        end
        `SDAC_OFS_LEVEL: begin
          prdata[AW+1:0] <= fifo_level;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule // sdac_top

// file: sim/sdac_checker.sv
// Purpose: Port assertions for the serial converter front end
// Assumes: Bound into sdac_top; mode bits are level outputs
// Notes:   Wake bound grows with WAKE_CYC
`timescale 1ns/1ps
module sdac_checker #(
  parameter WAKE_CYC = 500
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Converter controls
  input wire [7:0] conv_value,
  input wire pwrdn_sel_hi,
  input wire pwrdn_sel_lo,
  input wire amp_enable,
  input wire load_1k,
  input wire load_100k,
  input wire load_hiz,
  input wire output_valid
);
  localparam int WAKE_MAX = WAKE_CYC + 4;
  wire [1:0] pd = {pwrdn_sel_hi, pwrdn_sel_lo};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Mode decode, one switch per code
  chk_amp_mode: assert property (
    amp_enable == (pd == 2'h0)) else $error("amp enable off mode");
  chk_load_1k: assert property (
    load_1k == (pd == 2'h1)) else $error("1k load off mode");
  chk_load_100k: assert property (
    load_100k == (pd == 2'h2)) else $error("100k load off mode");
  chk_load_hiz: assert property (
    load_hiz == (pd == 2'h3)) else $error("hiz off mode");
  // ==========================================================
  // Power-down and wake timing
  sequence pd_held;
    (pd != 2'h0) ##1 (pd != 2'h0);
  endsequence
  sequence wake_event;
    (pd != 2'h0) ##1 (pd == 2'h0);
  endsequence
  chk_pd_invalid: assert property (
    pd_held |-> !output_valid) else $error("valid in power-down");
  chk_pd_now: assert property (
    (pd != 2'h0) |-> !output_valid)
    else $error("valid while powered down");
  chk_wake_delay: assert property (
    wake_event |-> !output_valid [*4] ##[1:WAKE_MAX] output_valid)
    else $error("wake timing wrong");
  chk_valid_rise: assert property (
    $rose(output_valid) |-> pd == 2'h0 && $past(pd) == 2'h0)
    else $error("valid rose outside normal mode");
  // Zero scale and normal mode straight after reset
  chk_reset_zero: assert property (
    $rose(presetn) |-> (conv_value == 8'h00 && pd == 2'h0) [*2])
    else $error("reset state wrong");
endmodule // sdac_checker

bind sdac_top sdac_checker #(.WAKE_CYC(WAKE_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .conv_value(conv_value),
  .pwrdn_sel_hi(pwrdn_sel_hi), .pwrdn_sel_lo(pwrdn_sel_lo),
  .amp_enable(amp_enable), .load_1k(load_1k), .load_100k(load_100k),
  .load_hiz(load_hiz), .output_valid(output_valid));

// file: sim/sdac_host.sv
// Purpose: Host model driving the three-wire serial link
// Assumes: Link clock period 800 ns, parked low between frames
// Notes:   Data line shows the inverted last bit once released
`timescale 1ns/1ps
module sdac_host (
  // Serial link pins
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // ==========================================================
  // One frame; fewer than 16 bits aborts it
  task automatic send(input logic [15:0] w, input int nbits);
    int i;
    #13;
    sync_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      #400 sclk = 1'b1; // 800 ns period, far under the limit
      din = (i < 16) ? w[15 - i] : ~din;
      #400 sclk = 1'b0;
    end
    #400 sync_n = 1'b1;
    din = ~din;
    #400; // High gap well above the minimum
  endtask
endmodule // sdac_host

// file: sim/sdac_top_bench.sv
// Purpose: Self-checking bench for the serial converter front end
// Assumes: Short wake count; host model drives the link pins
// Notes:   Random words come from a fixed seed
`timescale 1ns/1ps
`include "sdac_regs.vh"
module sdac_top_bench;
  localparam int WAKE = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sync_n, sclk, din, pd_hi, pd_lo;
  wire amp_enable, output_valid;
  wire [7:0] conv_value;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'h104f;
  logic [31:0] q;
  logic err;
  logic [15:0] w;
  logic [1:0] pm;
  int i;

  sdac_top #(.WAKE_CYC(WAKE)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_n(sync_n), .sclk(sclk), .din(din),
    .conv_value(conv_value), .pwrdn_sel_hi(pd_hi), .pwrdn_sel_lo(pd_lo),
    .amp_enable(amp_enable), .load_1k(), .load_100k(), .load_hiz(),
    .output_valid(output_valid));
  sdac_host host (.sync_n(sync_n), .sclk(sclk), .din(din));

  always #50 pclk = ~pclk;
  // Hang guard, well above the longest sequence
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Setup then access; held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Access stands until pready is seen; only the hang guard ends it
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] value_reg(input logic [15:0] wd);
    return {22'h0, wd[15:14], wd[13:6]};
  endfunction
  // Apply settles about 6 cycles after the last edge
  task automatic frame_check(input logic [15:0] wd);
    repeat (12) @(posedge pclk);
    check("conv_value", {24'h0, wd[13:6]}, {24'h0, conv_value});
    check("mode", {30'h0, wd[15:14]}, {30'h0, pd_hi, pd_lo});
    apb(1'b0, `SDAC_OFS_VALUE, 32'h0);
    check("value reg", value_reg(wd), q);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("reset value", 32'h0, {24'h0, conv_value});
    check("reset amp", 32'h3, {30'h0, amp_enable, output_valid});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    pm = 2'h0;
    // Random words, mode walked through all four codes
    for (i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      w[15:14] = i[1:0] ^ 2'h1;
      host.send(w, 16);
      frame_check(w);
      if (w[15:14] != 2'h0 || pm != 2'h0)
        check("valid low", 32'h0, {31'h0, output_valid});
      if (w[15:14] == 2'h0 && pm != 2'h0) begin
        repeat (WAKE + 4) @(posedge pclk);
        check("valid back", 32'h1, {31'h0, output_valid});
      end
      pm = w[15:14];
    end
    // Early sync rise, then a write to a read-only place
    host.send(~w, 10);
    apb(1'b1, `SDAC_OFS_VALUE, 32'hffff_ffff);
    frame_check(w);
    apb(1'b0, `SDAC_OFS_STATUS, 32'h0);
    check("abort flag", 32'h8, q & 32'h8);
    apb(1'b1, `SDAC_OFS_STATUS, 32'h8);
    apb(1'b0, `SDAC_OFS_STATUS, 32'h0);
    check("abort clear", 32'h0, q & 32'h8);
    // Edges past the sixteenth are ignored
    w = 16'($random(seed));
    w[15:14] = 2'h0;
    host.send(w, 20);
    frame_check(w);
    // Hold words in the FIFO until it refuses, then drain
    apb(1'b1, `SDAC_OFS_CTRL, 32'h1);
    for (i = 0; i < 34; i++)
      host.send({2'h0, i[7:0], 6'h2a}, 16);
    repeat (12) @(posedge pclk);
    check("held value", {24'h0, w[13:6]}, {24'h0, conv_value});
    apb(1'b0, `SDAC_OFS_LEVEL, 32'h0);
    check("fifo level", 32'h21, q & 32'h7f);
    apb(1'b0, `SDAC_OFS_STATUS, 32'h0);
    check("full overflow", 32'h6, q & 32'h7);
    apb(1'b1, `SDAC_OFS_CTRL, 32'h0);
    repeat (300) @(posedge pclk);
    check("drained value", 32'h20, {24'h0, conv_value});
    apb(1'b0, `SDAC_OFS_STATUS, 32'h0);
    check("drained empty", 32'h1, q & 32'h3);
    test_done();
  end
endmodule // sdac_top_bench
